// File: verilog/icc_pkg.sv
package icc_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets.
    // ------------------------------------------------------------------
    localparam logic [4:0] OFS_CTRL     = 5'h00; // Control word.
    localparam logic [4:0] OFS_STATUS   = 5'h04; // Buffer and pin status.
    localparam logic [4:0] OFS_DATA     = 5'h08; // Oldest capture, popped on read.
    localparam logic [4:0] OFS_IRQ_STAT = 5'h0c; // Sticky event bits, write one to clear.
    localparam logic [4:0] OFS_IRQ_MASK = 5'h10; // Event enables.

    // ------------------------------------------------------------------
    // Control field positions and reset value.
    // ------------------------------------------------------------------
    localparam int CTRL_ENABLE   = 0;  // Channel on.
    localparam int CTRL_MODE_LO  = 1;  // Mode field, three bits.
    localparam int CTRL_FIRSTRISE = 4; // First edge polarity, one is rising.
    localparam int CTRL_SEL_LO   = 5;  // Time base select, two bits.
    localparam int CTRL_LVL_LO   = 7;  // Interrupt fill level minus one, two bits.
    localparam int CTRL_WAKE     = 9;  // Wake request enable.
    localparam int CTRL_WIDTH    = 10; // Implemented control bits.
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Status and interrupt field positions.
    // ------------------------------------------------------------------
    localparam int STAT_NOTEMPTY = 0; // Buffer holds data.
    localparam int STAT_COUNT_LO = 1; // Entry count, three bits.
    localparam int STAT_OVERFLOW = 4; // Sticky overflow.
    localparam int STAT_PIN      = 5; // Current pin level.
    localparam int IRQ_EVENT     = 0; // Qualifying event seen.
    localparam int IRQ_LEVEL     = 1; // Fill level reached.
    localparam int IRQ_OVERFLOW  = 2; // Capture lost on a full buffer.
    localparam int IRQ_WIDTH     = 3;
    localparam logic [IRQ_WIDTH-1:0] IRQ_RESET = 3'h0;

    // ------------------------------------------------------------------
    // Modes, sources, prescale counts.
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_OFF     = 3'h0, // No events.
        MODE_BOTH    = 3'h1, // Every edge.
        MODE_FALL    = 3'h2, // Every falling edge.
        MODE_RISE    = 3'h3, // Every rising edge.
        MODE_DIV4    = 3'h4, // Every fourth rising edge.
        MODE_DIV16   = 3'h5, // Every sixteenth rising edge.
        MODE_FIRST   = 3'h6, // Every edge after a chosen first edge.
        MODE_IRQONLY = 3'h7  // Chosen edge raises an event only.
    } icc_mode_t;

    typedef enum logic [1:0] {
        SEL_A     = 2'h0, // First time base.
        SEL_B     = 2'h1, // Second time base.
        SEL_CHAIN = 2'h2  // Both chained, second is the upper half.
    } icc_sel_t;

    localparam logic [3:0] PRE_LAST4  = 4'h3; // Counter value on the fourth edge.
    localparam logic [3:0] PRE_LAST16 = 4'hf; // Counter value on the sixteenth edge.

    // Decoded control word.
    typedef struct packed {
        logic      wake;
        logic [1:0] level;
        icc_sel_t  sel;
        logic      firstRise;
        icc_mode_t mode;
        logic      enable;
    } icc_ctrl_t;

    // Channel state, one-hot.
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001, // Off or just reconfigured.
        ST_ARMED = 3'b010, // Waiting for the chosen first edge.
        ST_RUN   = 3'b100  // Capturing.
    } icc_state_t;

endpackage : icc_pkg

// File: verilog/icc_capture.sv
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps

// Functional notes
// - Latch selected time base on qualifying event.
// - Rising-only and falling-only capture modes.
// - Every-edge mode captures both polarities.
// - Every-edge mode waits for chosen first edge.
// - Capture every fourth rising edge.
// - Capture every sixteenth rising edge.
// - Select base A, B, or chained pair.
// - Capture event requests wake from low power.
// - Capture events raise an interrupt.
// - Four-entry FIFO read in capture order.
// - Interrupt after one to four entries.
// - Usable as a plain external interrupt.
module icc_capture #(
    parameter int DEPTH = 4,  // Buffer entries.
    parameter int TBW   = 16  // Width of one time base.
) (
    input  wire logic        ref_clk,          // System clock.
    input  wire logic        rst,              // Synchronous reset, active high.
    input  wire logic        capPin,           // Capture input pin.
    input  wire logic [TBW-1:0] timeBaseA,     // First time base count.
    input  wire logic [TBW-1:0] timeBaseB,     // Second time base count.
    input  wire logic [4:0]  avs_address,      // Byte address.
    input  wire logic        avs_read,         // Read strobe.
    input  wire logic        avs_write,        // Write strobe.
    input  wire logic [31:0] avs_writedata,    // Write data.
    input  wire logic [3:0]  avs_byteenable,   // Byte lanes.
    output logic [31:0]      avs_readdata,     // Read data.
    output logic             avs_waitrequest,  // Stall.
    output logic             irq,              // Level interrupt.
    output logic             wakeRequest       // One-cycle wake pulse.
);

    // ------------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------------
    localparam int PW = $clog2(DEPTH); // Pointer width.
    localparam int CW = PW + 1;        // Count width.

    localparam int CTRL_WIDTH_L = icc_pkg::CTRL_WIDTH; // Implemented control bits.
    logic [CTRL_WIDTH_L-1:0] ctrlBits; // Raw control register.
    icc_pkg::icc_ctrl_t      ctrl;       // Decoded control.
    logic [icc_pkg::IRQ_WIDTH-1:0] irqStat; // Sticky events.
    logic [icc_pkg::IRQ_WIDTH-1:0] irqMask; // Event enables.
    icc_pkg::icc_state_t     state;      // Channel state.
    icc_pkg::icc_state_t     next_state; // Next channel state.
    logic                    pinPrev;    // Pin one cycle ago.
    logic [3:0]              preCount;   // Rising edge prescaler.
    logic [2*TBW-1:0]        fifoMem [DEPTH]; // Capture storage.
    logic [PW-1:0]           wrPtr;      // Next slot to fill.
    logic [PW-1:0]           rdPtr;      // Oldest slot.
    logic [CW-1:0]           count;      // Entries held.
    logic                    overflow;   // Sticky overflow.
    logic                    rdAck;      // Read wait state done.
    logic [31:0]             next_readdata; // Selected read word.
    logic [31:0]             ctrlMerged; // Control after byte lanes.

    // ------------------------------------------------------------------
    // Decode.
    // ------------------------------------------------------------------
    wire        rise      = capPin & ~pinPrev;   // Rising edge this cycle.
    wire        fall      = ~capPin & pinPrev;   // Falling edge this cycle.
    wire        anyEdge   = rise | fall;         // Either edge.
    wire        firstEdge = ctrl.firstRise ? rise : fall; // Chosen polarity edge.
    wire        running   = (state == icc_pkg::ST_RUN);
    wire        selCtrl   = (avs_address == icc_pkg::OFS_CTRL);
    wire        selStat   = (avs_address == icc_pkg::OFS_STATUS);
    wire        selData   = (avs_address == icc_pkg::OFS_DATA);
    wire        selIrqS   = (avs_address == icc_pkg::OFS_IRQ_STAT);
    wire        selIrqM   = (avs_address == icc_pkg::OFS_IRQ_MASK);
    wire        wrCtrl    = avs_write & selCtrl;
    wire        wrIrqS    = avs_write & selIrqS & avs_byteenable[0];
    wire        wrIrqM    = avs_write & selIrqM & avs_byteenable[0];
    wire        popAccept = avs_read & rdAck & selData; // Read completes at this edge.
    wire        full      = (count == CW'(DEPTH));
    wire        empty     = (count == '0);
    wire        pop       = popAccept & ~empty;

    assign ctrl = icc_pkg::icc_ctrl_t'(ctrlBits);

    // Edge that counts as an event for the current mode.
    logic modeEdge;
    always_comb begin
        modeEdge = 1'b0;
        case (ctrl.mode)
            icc_pkg::MODE_BOTH:    modeEdge = anyEdge;
            icc_pkg::MODE_FALL:    modeEdge = fall;
            icc_pkg::MODE_RISE:    modeEdge = rise;
            icc_pkg::MODE_DIV4:    modeEdge = rise & (preCount[1:0] == icc_pkg::PRE_LAST4[1:0]);
            icc_pkg::MODE_DIV16:   modeEdge = rise & (preCount == icc_pkg::PRE_LAST16);
            icc_pkg::MODE_FIRST:   modeEdge = anyEdge;
            icc_pkg::MODE_IRQONLY: modeEdge = firstEdge;
            default:               modeEdge = 1'b0;
        endcase
    end

    // The armed state turns the chosen first edge into the first event.
    wire armedHit  = (state == icc_pkg::ST_ARMED) & firstEdge;
    wire event_    = ctrl.enable & ((running & modeEdge) | armedHit);
    wire capture   = event_ & (ctrl.mode != icc_pkg::MODE_IRQONLY);
    wire push      = capture & ~full;
    wire lost      = capture & full;

    // Both halves are taken from the same edge, so a carry cannot split them.
    logic [2*TBW-1:0] stamp;
    always_comb begin
        stamp = '0;
        case (ctrl.sel)
            icc_pkg::SEL_A:     stamp = {{TBW{1'b0}}, timeBaseA};
            icc_pkg::SEL_B:     stamp = {{TBW{1'b0}}, timeBaseB};
            icc_pkg::SEL_CHAIN: stamp = {timeBaseB, timeBaseA};
            default:            stamp = {{TBW{1'b0}}, timeBaseA};
        endcase
    end

    // Fill level threshold from the two level bits, one to four entries.
    wire [CW-1:0] threshold = CW'({1'b0, ctrl.level}) + CW'(1);
    wire          levelHit  = (count >= threshold);

    // ------------------------------------------------------------------
    // Channel state machine.
    // ------------------------------------------------------------------
    // A control write or a disabled channel restarts from idle.
    always_comb begin
        next_state = state;
        case (state)
            icc_pkg::ST_IDLE: begin
                if (ctrl.enable && ctrl.mode != icc_pkg::MODE_OFF) begin
                    next_state = (ctrl.mode == icc_pkg::MODE_FIRST) ? icc_pkg::ST_ARMED : icc_pkg::ST_RUN;
                end
            end
            icc_pkg::ST_ARMED: begin
                if (firstEdge) begin
                    next_state = icc_pkg::ST_RUN;
                end
            end
            icc_pkg::ST_RUN:   next_state = icc_pkg::ST_RUN;
            default:           next_state = icc_pkg::ST_IDLE;
        endcase
        if (wrCtrl || !ctrl.enable) begin
            next_state = icc_pkg::ST_IDLE;
        end
    end

    // State and pin history.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state   <= icc_pkg::ST_IDLE;
            pinPrev <= 1'b0;
        end else begin
            state   <= next_state;
            pinPrev <= capPin;
        end
    end

    // Prescaler counts rising edges while running; restarts with the state.
    always_ff @(posedge ref_clk) begin
        if (rst || !running) begin
            preCount <= 4'h0;
        end else if (rise) begin
            preCount <= preCount + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // Capture buffer.
    // ------------------------------------------------------------------
    // Storage is written only on a push; entries are never overwritten.
    always_ff @(posedge ref_clk) begin
        if (push) begin
            fifoMem[wrPtr] <= stamp;
        end
    end

    // Pointers and count move together; a push and a pop may share a cycle.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wrPtr <= wrPtr + PW'(1);
            end
            if (pop) begin
                rdPtr <= rdPtr + PW'(1);
            end
            count <= count + CW'(push) - CW'(pop);
        end
    end

    // Overflow stays set until the buffer is drained; a new loss wins.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            overflow <= 1'b0;
        end else if (lost) begin
            overflow <= 1'b1;
        end else if (pop && count == CW'(1)) begin
            overflow <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt and wake.
    // ------------------------------------------------------------------
    wire [icc_pkg::IRQ_WIDTH-1:0] irqSet;
    assign irqSet[icc_pkg::IRQ_EVENT]    = event_;
    assign irqSet[icc_pkg::IRQ_LEVEL]    = levelHit;
    assign irqSet[icc_pkg::IRQ_OVERFLOW] = lost;

    wire [icc_pkg::IRQ_WIDTH-1:0] irqClr = wrIrqS ? avs_writedata[icc_pkg::IRQ_WIDTH-1:0] : '0;

    // Sticky events: a set in the same cycle as its clear is kept.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irqStat <= icc_pkg::IRQ_RESET;
        end else begin
            irqStat <= (irqStat & ~irqClr) | irqSet;
        end
    end

    assign irq = |(irqStat & irqMask);

    // Wake pulse on every event while the wake enable is set.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wakeRequest <= 1'b0;
        end else begin
            wakeRequest <= event_ & ctrl.wake;
        end
    end

    // ------------------------------------------------------------------
    // Register slave.
    // ------------------------------------------------------------------
    // Control write honours byte lanes.
    always_comb begin
        ctrlMerged = {{(32-CTRL_WIDTH_L){1'b0}}, ctrlBits};
        for (int i = 0; i < 4; i++) begin
            if (avs_byteenable[i]) begin
                ctrlMerged[8*i +: 8] = avs_writedata[8*i +: 8];
            end
        end
    end

    // Control and mask registers.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrlBits <= icc_pkg::CTRL_RESET[CTRL_WIDTH_L-1:0];
            irqMask  <= icc_pkg::IRQ_RESET;
        end else begin
            if (wrCtrl) begin
                ctrlBits <= ctrlMerged[CTRL_WIDTH_L-1:0];
            end
            if (wrIrqM) begin
                irqMask <= avs_writedata[icc_pkg::IRQ_WIDTH-1:0];
            end
        end
    end

    // Status word.
    wire [31:0] statusWord = {26'h0, capPin, overflow, 3'(count), ~empty};

    // Read word; data reads only the bits the selected source provides.
    wire [2*TBW-1:0] head     = fifoMem[rdPtr];
    wire [31:0]      dataWord = empty ? 32'h0 :
                                (ctrl.sel == icc_pkg::SEL_CHAIN) ? 32'(head) : 32'(head[TBW-1:0]);
    assign next_readdata = selCtrl ? {{(32-CTRL_WIDTH_L){1'b0}}, ctrlBits} :
                           selStat ? statusWord :
                           selData ? dataWord :
                           selIrqS ? {{(32-icc_pkg::IRQ_WIDTH){1'b0}}, irqStat} :
                           selIrqM ? {{(32-icc_pkg::IRQ_WIDTH){1'b0}}, irqMask} :
                           32'h0;

    // Reads take one wait state; writes complete at once.
    assign avs_waitrequest = avs_read & ~rdAck;

    // Read data is latched in the wait cycle and stands at the completing edge.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdAck        <= 1'b0;
            avs_readdata <= 32'h0;
        end else begin
            rdAck <= avs_read & ~rdAck;
            if (avs_read && !rdAck) begin
                avs_readdata <= next_readdata;
            end
        end
    end

endmodule : icc_capture

// File: tb/icc_capture_props.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Port checker for the capture channel.
// ----------------------------------------------------------------------
module icc_capture_props #(
    parameter int TBW = 16 // Width of one time base.
) (
    input wire logic           ref_clk,
    input wire logic           rst,
    input wire logic           capPin,
    input wire logic [TBW-1:0] timeBaseA,
    input wire logic [TBW-1:0] timeBaseB,
    input wire logic [4:0]     avs_address,
    input wire logic           avs_read,
    input wire logic           avs_write,
    input wire logic [31:0]    avs_writedata,
    input wire logic [3:0]     avs_byteenable,
    input wire logic [31:0]    avs_readdata,
    input wire logic           avs_waitrequest,
    input wire logic           irq,
    input wire logic           wakeRequest
);
    logic [2:0] maskCopy; // Interrupt mask as last written.
    logic       chainSel; // Chained pair chosen as source.
    wire        rdDone = avs_read && !avs_waitrequest; // A read completes here.

    // Every property samples on the system clock and sleeps in reset.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // Mirror the mask and source writes so the checks can see them.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            maskCopy <= 3'h0;
            chainSel <= 1'b0;
        end else if (avs_write && avs_byteenable[0]) begin
            if (avs_address == icc_pkg::OFS_IRQ_MASK) maskCopy <= avs_writedata[2:0];
            if (avs_address == icc_pkg::OFS_CTRL) chainSel <= avs_writedata[6:5] == 2'h2;
        end
    end

    a_read_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("Read did not finish after one wait cycle.");
    a_write_nowait: assert property (avs_write |-> !avs_waitrequest)
        else $error("Write was stalled.");
    a_reset_quiet: assert property ($past(rst) |-> !irq && !wakeRequest)
        else $error("Interrupt or wake active after reset.");
    a_wake_edge: assert property (wakeRequest |-> $past(capPin) != $past(capPin, 2))
        else $error("Wake pulse without a pin edge one cycle earlier.");
    a_masked_quiet: assert property (maskCopy == 3'h0 |-> !irq)
        else $error("Interrupt raised with every event masked.");
    a_unmapped_zero: assert property (rdDone && avs_address > 5'h10 |-> avs_readdata == 32'h0)
        else $error("Unmapped address did not read zero.");
    a_status_fields: assert property (rdDone && avs_address == icc_pkg::OFS_STATUS |->
        avs_readdata[3:1] <= 3'h4 && avs_readdata[0] == (avs_readdata[3:1] != 3'h0))
        else $error("Buffer count and nonempty flag disagree.");
    a_data_width: assert property (rdDone && avs_address == icc_pkg::OFS_DATA && !chainSel |->
        avs_readdata[31:16] == 16'h0)
        else $error("Single time base capture has upper bits set.");
    a_readdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("Read data changed without a read.");
endmodule : icc_capture_props

bind icc_capture icc_capture_props #(.TBW(TBW)) u_props (.ref_clk, .rst, .capPin, .timeBaseA, .timeBaseB,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .irq, .wakeRequest);

// File: tb/icc_pin_src.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// External signal source that drives the capture pin.
// ----------------------------------------------------------------------
module icc_pin_src (
    input wire logic       ref_clk,
    input wire logic       target,  // Level the source should move to.
    input wire logic [1:0] lag,     // Cycles it waits before following.
    output logic           capPin
);
    logic [1:0] waitCnt; // Cycles waited so far.

    initial begin
        capPin = 1'b0;
        waitCnt = 2'h0;
    end

    // Follow the requested level promptly or after a few idle cycles.
    always @(posedge ref_clk) begin
        if (capPin == target) waitCnt <= 2'h0;
        else if (waitCnt >= lag) begin
            capPin <= target;
            waitCnt <= 2'h0;
        end else waitCnt <= waitCnt + 2'h1;
    end
endmodule : icc_pin_src

// File: tb/tb.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Self-checking bench for the capture channel.
// ----------------------------------------------------------------------
module tb;
    logic        ref_clk = 1'b0;           // System clock.
    logic        rst = 1'b1;               // Synchronous reset.
    logic        target = 1'b0;            // Level asked of the pin source.
    logic [1:0]  lag = 2'h0;               // Pin source delay.
    logic [31:0] stamp = 32'h0000_fff0;    // Chained time base, carries early.
    logic [4:0]  adr = 5'h0;               // Bus address.
    logic        rd = 1'b0;                // Read strobe.
    logic        wr = 1'b0;                // Write strobe.
    logic [31:0] wdat = 32'h0;             // Write data.
    logic [31:0] rdat, got;                // Read data, last answer.
    logic        capPin, waitReq, irq, wake, prev;
    logic [2:0]  mode = 3'h0;              // Mode of the reference model.
    logic [3:0]  pre;                      // Rising edges counted.
    logic        fr, armed, ovf, lvlHit;
    logic [1:0]  sel, lvl;
    logic [2:0]  mask;
    logic [31:0] q[$];                     // Expected buffer contents.
    int          bad_count = 0;            // Mismatches.
    int          check_count = 0;          // Comparisons.
    int          hits, wakes, nt;

    always #12.5 ref_clk = ~ref_clk;
    // The time base advances by a random step each cycle.
    always @(posedge ref_clk) stamp <= stamp + 32'($urandom_range(1, 3));

    icc_pin_src u_src (.ref_clk(ref_clk), .target(target), .lag(lag), .capPin(capPin));
    icc_capture DUT (.ref_clk(ref_clk), .rst(rst), .capPin(capPin), .timeBaseA(stamp[15:0]),
        .timeBaseB(stamp[31:16]), .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
        .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(waitReq), .irq(irq),
        .wakeRequest(wake));

    // Decide whether a pin edge is a qualifying event in the current mode.
    function automatic logic hit(input logic r);
        case (mode)
            3'h1: return 1'b1;
            3'h2: return !r;
            3'h3: return r;
            3'h4: return r && pre == 4'h3;
            3'h5: return r && pre == 4'hf;
            3'h6, 3'h7: return armed || r == fr;
            default: return 1'b0;
        endcase
    endfunction : hit

    // Reference model: stamps each qualifying edge into the expected buffer.
    always @(posedge ref_clk) begin
        prev <= capPin;
        if (wake === 1'b1) wakes = wakes + 1;
        if (!rst && capPin !== prev && prev !== 1'bx) begin
            if (hit(capPin)) begin
                hits = hits + 1;
                if (mode == 3'h6) armed = 1'b1;
                if (mode != 3'h7 && q.size() < 4) q.push_back(stamp);
                else if (mode != 3'h7) ovf = 1'b1;
                if (capPin) pre = 4'h0;
            end else if (capPin) pre = pre + 4'h1;
        end
    end

    // Compare one value and count the outcome.
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // One bus cycle: hold the request until waitrequest is sampled low.
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        adr <= a;
        wdat <= d;
        rd <= !w;
        wr <= w;
        @(posedge ref_clk);
        while (waitReq !== 1'b0 && n < 20) begin
            n++;
            @(posedge ref_clk);
        end
        if (n == 20) begin
            bad_count++;
            test_done();
        end
        got = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge ref_clk);
    endtask : bus

    // Ask the source for the other level and wait until the pin follows.
    task automatic toggle();
        int k;
        target <= ~target;
        lag <= 2'($urandom);
        @(posedge ref_clk);
        for (k = 0; capPin !== target && k < 10; k++) @(posedge ref_clk);
        if (k == 10) begin
            bad_count++;
            test_done();
        end
        repeat ($urandom_range(0, 2)) @(posedge ref_clk);
    endtask : toggle

    // Print the counts and the verdict, then stop.
    task automatic test_done();
        $display("Checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : test_done

    initial begin
        void'($urandom(47571));
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        // Every register and unmapped address 0x14 read zero after reset.
        bus(1'b1, 5'h14, 32'hffff_ffff);
        for (int a = 0; a < 24; a += 4) begin
            bus(1'b0, 5'(a), 32'h0);
            chk("reset value", got, 32'h0);
        end
        $display("Test reset values done");
        // Walk every mode with random source, polarity, level, mask and wake.
        for (int m = 0; m < 8; m++) begin
            sel = 2'($urandom);
            {fr, lvl, mask} = 6'($urandom);
            nt = m > 3 ? 34 : $urandom_range(2, 9);
            bus(1'b1, 5'h10, {29'h0, mask});
            bus(1'b1, 5'h00, {22'h0, m[0] ^ fr, lvl, sel, fr, 3'(m), 1'b1});
            {mode, pre, armed, ovf, hits, wakes} = {3'(m), 4'h0, 1'b0, 1'b0, 64'h0};
            q.delete();
            repeat (nt) toggle();
            repeat (3) @(posedge ref_clk);
            lvlHit = q.size() >= lvl + 1;
            chk("irq", irq, |({ovf, lvlHit, hits != 0} & mask));
            chk("wake", wakes, (m[0] ^ fr) ? hits : 0);
            bus(1'b0, 5'h0c, 32'h0);
            chk("irq status", got, {29'h0, ovf, lvlHit, hits != 0});
            bus(1'b0, 5'h04, 32'h0);
            chk("status", got[4:0], {ovf, 3'(q.size()), q.size() != 0});
            while (q.size() > 0) begin
                bus(1'b0, 5'h08, 32'h0);
                chk("capture", got, sel == 2'h2 ? q[0] : sel == 2'h1 ? q[0] >> 16 : q[0] & 32'hffff);
                void'(q.pop_front());
            end
            bus(1'b0, 5'h08, 32'h0);
            chk("empty read", got, 32'h0);
            bus(1'b0, 5'h04, 32'h0);
            chk("drained status", got[4:0], 5'h0);
            bus(1'b1, 5'h0c, 32'h7);
            bus(1'b0, 5'h0c, 32'h0);
            chk("cleared status", got, 32'h0);
            chk("irq cleared", irq, 1'b0);
            $display("Test mode %0d done", m);
        end
        test_done();
    end
endmodule : tb
